// >>> include/qdac_cfg.svh
// Constants for the quad DAC serial command decoder.
// Assumes inclusion by bare name from the include path.
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define QDAC_FRAME_BITS 16
`define QDAC_CMD_MSB 15
`define QDAC_CMD_LSB 12
`define QDAC_CODE_MSB 11
`define QDAC_CODE_LSB 0
`define QDAC_CODE_W 12
`define QDAC_CH_N 4
`define QDAC_KEEP_BITS 15

// ----------------------------------------
// Command groups and power-down fields
// ----------------------------------------
`define QDAC_GRP_DIRECT 2'h0
`define QDAC_GRP_INPUT 2'h1
`define QDAC_GRP_XFER 2'h2
`define QDAC_GRP_ALL 2'h3
`define QDAC_ALL_DIRECT 2'h0
`define QDAC_ALL_INPUT 2'h1
`define QDAC_ALL_XFER 2'h2
`define QDAC_ALL_POWER 2'h3
`define QDAC_PD_ALL_BIT 4
`define QDAC_PD_CH_MSB 3
`define QDAC_PD_CH_LSB 2
`define QDAC_PD_MODE_MSB 1
`define QDAC_PD_MODE_LSB 0
`define QDAC_RESET_CODE 12'h000
`define QDAC_COUNT_ZERO 5'h00
`define QDAC_COUNT_ONE 5'h01

`endif

// >>> include/qdac_pkg.sv
// Types shared by the quad DAC command decoder.
// Assumes qdac_cfg.svh is on the include path.
`include "qdac_cfg.svh"

package qdac_pkg;
    typedef logic [`QDAC_CODE_W-1:0] qdac_code_t;
    typedef logic [`QDAC_FRAME_BITS-1:0] qdac_word_t;
    typedef enum logic [1:0] {
        QDAC_PD_WAKE,
        QDAC_PD_FLOAT,
        QDAC_PD_1K,
        QDAC_PD_100K
    } qdac_pd_e;
endpackage : qdac_pkg

// >>> include/qdac_frame_if.sv
// Carries a received frame from the serial front end to the decoder.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface qdac_frame_if;
    import qdac_pkg::*;
    logic frame_valid;
    qdac_word_t frame_word;
    modport source (output frame_valid, output frame_word);
    modport sink (input frame_valid, input frame_word);
endinterface : qdac_frame_if

`default_nettype wire

// >>> hdl/qdac_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is a pin outside sys_clk's domain.
`timescale 1ns/1ps
`default_nettype none

module qdac_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic async_in,
    input wire logic reset_level,
    output logic sync_out
);
    logic meta_reg;
    logic sync_reg;

    // Reset takes the idle level; the value is a constant at each instance
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= reset_level;
            sync_reg <= reset_level;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : qdac_sync

`default_nettype wire

// >>> hdl/qdac_shifter.sv
// Serial front end: samples the link, shifts 16 bits, hands a frame on.
// Assumes the link clock is far slower than sys_clk (80 ns vs 10 ns).
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"

module qdac_shifter
    import qdac_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    // Frame out
    qdac_frame_if.source frame,
    // Status
    output logic buffers_on
);
    logic cs_n_s;
    logic sclk_s;
    logic sdi_s;
    logic cs_n_d_reg;
    logic sclk_d_reg;
    logic en_reg;
    logic [4:0] cnt_reg;
    qdac_word_t sh_reg;
    qdac_word_t word_reg;
    logic valid_reg;

    // (R17) Synchronise pins
    qdac_sync u_cs (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(cs_n),
        .reset_level(1'b1), .sync_out(cs_n_s));
    qdac_sync u_ck (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(sclk),
        .reset_level(1'b0), .sync_out(sclk_s));
    qdac_sync u_di (.sys_clk(sys_clk), .rst_n(rst_n), .async_in(sdi),
        .reset_level(1'b0), .sync_out(sdi_s));

    wire cs_fall = cs_n_d_reg & ~cs_n_s;
    wire sclk_fall = sclk_d_reg & ~sclk_s;
    // (R13) Sample on falling edge
    wire take_bit = en_reg & ~cs_n_s & sclk_fall;
    wire last_bit = take_bit & (cnt_reg == 5'(`QDAC_FRAME_BITS - 1));
    // (R16) MSB arrives first
    wire [`QDAC_FRAME_BITS-1:0] sh_next = {sh_reg[`QDAC_FRAME_BITS-2:0], sdi_s};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cs_n_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
        end else begin
            cs_n_d_reg <= cs_n_s;
            sclk_d_reg <= sclk_s;
        end
    end

    // (R2) Re-enable on select fall
    // (R1) Gate off after bit sixteen
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_reg <= 1'b0;
        end else if (cs_fall) begin
            en_reg <= 1'b1;
        end else if (last_bit) begin
            en_reg <= 1'b0;
        end
    end

    // (R14) Early select rise discards frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n || cs_fall || cs_n_s) begin
            cnt_reg <= `QDAC_COUNT_ZERO;
        end else if (take_bit) begin
            cnt_reg <= cnt_reg + `QDAC_COUNT_ONE;
        end
    end

    // (R3) Assemble 16-bit frame
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sh_reg <= '0;
            word_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= last_bit;
            if (take_bit) begin
                sh_reg <= sh_next;
            end
            if (last_bit) begin
                word_reg <= sh_next;
            end
        end
    end

    assign frame.frame_valid = valid_reg;
    assign frame.frame_word = word_reg;
    assign buffers_on = en_reg;
endmodule : qdac_shifter

`default_nettype wire

// >>> hdl/qdac_decoder.sv
// Quad 12-bit DAC serial command decoder, top level.
// Assumes a 3-wire serial master on the pins; outputs feed analog stages.
//
// Operation
// (R1) Serial input buffers switch off once sixteen bits are shifted.
// (R2) Falling chip select switches the serial input buffers back on.
// (R3) Frame is 16 bits, MSB first; top 4 command, low 12 code.
// (R4) Commands 0-3 load one output register directly and update it.
// (R5) Commands 4-7 load only one input register; output unchanged.
// (R6) Commands 8-11 copy one input register to output; data ignored.
// (R7) Command 12 loads all four output registers directly together.
// (R8) Command 13 loads all four input registers; outputs unchanged.
// (R9) Command 14 copies all input registers to outputs together.
// (R10) Channel code is straight unsigned binary, 4096 steps.
// (R11) Host uses offset binary for bipolar; midscale means zero.
// (R12) Command 15 sets power-down mode for one or all channels.
// (R13) Data sampled on falling serial clock; word acted on after 16.
// (R14) Chip select rising before sixteen bits discards the frame.
// (R15) Reset clears registers and powers down with 100k termination.
// (R16) Host shifts command bit 3 first and data bit 0 last.
// (R17) Pins are synchronised to sys_clk before edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"

module qdac_decoder
    import qdac_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    // Channel outputs
    output logic [`QDAC_CODE_W-1:0] channel_a_output,
    output logic [`QDAC_CODE_W-1:0] channel_b_output,
    output logic [`QDAC_CODE_W-1:0] channel_c_output,
    output logic [`QDAC_CODE_W-1:0] channel_d_output,
    // Power-down modes, two bits per channel, A in the low pair
    output logic [2*`QDAC_CH_N-1:0] channel_pd_mode,
    // Status
    output logic input_buffers_on,
    output logic update_pulse
);
    qdac_frame_if frame_bus ();

    qdac_shifter u_shift (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdi(sdi),
        .frame(frame_bus.source),
        .buffers_on(input_buffers_on)
    );

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire go = frame_bus.frame_valid;
    wire [3:0] command_field = frame_bus.frame_word[`QDAC_CMD_MSB:`QDAC_CMD_LSB];
    // (R10) Code kept as plain unsigned binary
    wire [`QDAC_CODE_W-1:0] channel_code =
        frame_bus.frame_word[`QDAC_CODE_MSB:`QDAC_CODE_LSB];
    wire [1:0] grp = command_field[3:2];
    wire [1:0] sel = command_field[1:0];
    wire is_all = (grp == `QDAC_GRP_ALL);
    wire pd_cmd = go & is_all & (sel == `QDAC_ALL_POWER);
    wire pd_all = channel_code[`QDAC_PD_ALL_BIT];
    wire [1:0] pd_ch = channel_code[`QDAC_PD_CH_MSB:`QDAC_PD_CH_LSB];
    wire [1:0] pd_mode = channel_code[`QDAC_PD_MODE_MSB:`QDAC_PD_MODE_LSB];

    // Per-channel hit for single or broadcast forms
    function automatic logic hit(input logic [1:0] g, input logic [1:0] a,
                                 input logic [1:0] ch);
        hit = ((grp == g) & (sel == ch)) | (is_all & (sel == a));
    endfunction : hit

    qdac_code_t in_reg [`QDAC_CH_N];
    qdac_code_t out_reg [`QDAC_CH_N];
    logic [1:0] pd_reg [`QDAC_CH_N];
    logic upd_reg;

    // ----------------------------------------
    // Channel registers
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `QDAC_CH_N; gi++) begin : g_ch
            // (R4) Direct write, input made transparent
            // (R7) Broadcast direct write
            wire direct = go & hit(`QDAC_GRP_DIRECT, `QDAC_ALL_DIRECT, 2'(gi));
            // (R5) Input register only
            // (R8) Broadcast input load
            wire load_in = go & hit(`QDAC_GRP_INPUT, `QDAC_ALL_INPUT, 2'(gi));
            // (R6) Transfer, frame data ignored
            // (R9) Broadcast transfer
            wire xfer = go & hit(`QDAC_GRP_XFER, `QDAC_ALL_XFER, 2'(gi));
            // (R12) Power-down target
            wire pd_hit = pd_cmd & (pd_all | (pd_ch == 2'(gi)));

            // (R15) Reset clears to zero, 100k termination
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    in_reg[gi] <= `QDAC_RESET_CODE;
                    out_reg[gi] <= `QDAC_RESET_CODE;
                    pd_reg[gi] <= QDAC_PD_100K;
                end else begin
                    if (direct | load_in) begin
                        in_reg[gi] <= channel_code;
                    end
                    if (direct) begin
                        out_reg[gi] <= channel_code;
                    end else if (xfer) begin
                        out_reg[gi] <= in_reg[gi];
                    end
                    if (pd_hit) begin
                        pd_reg[gi] <= pd_mode;
                    end
                end
            end
            assign channel_pd_mode[2*gi+1:2*gi] = pd_reg[gi];
        end
    endgenerate

    // One-cycle marker that any output register was loaded
    wire any_upd = go & ((grp == `QDAC_GRP_DIRECT) | (grp == `QDAC_GRP_XFER)
        | (is_all & ((sel == `QDAC_ALL_DIRECT) | (sel == `QDAC_ALL_XFER))));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= any_upd;
        end
    end

    assign channel_a_output = out_reg[0];
    assign channel_b_output = out_reg[1];
    assign channel_c_output = out_reg[2];
    assign channel_d_output = out_reg[3];
    assign update_pulse = upd_reg;
endmodule : qdac_decoder

`default_nettype wire

// >>> tb/qdac_host_model.sv
// Serial master model: one frame per call, MSB first.
// Assumes sys_clk at 10 ns; link clock period 80 ns.
`timescale 1ns/1ps
`default_nettype none
module qdac_host_model (
    // Clock
    input wire logic sys_clk,
    // Serial link
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    task automatic half;
        repeat (4) @(posedge sys_clk);
    endtask : half
    // Command bit 3 first, data bit 0 last
    task automatic frame(input logic [15:0] w, input int n, input int extra);
        cs_n <= 1'b0;
        half();
        for (int i = 0; i < n + extra; i++) begin
            sdi <= (i < n) ? w[15-i] : ~sdi;
            sclk <= 1'b1;
            half();
            sclk <= 1'b0;
            half();
        end
        // Early rise of select abandons a short frame
        cs_n <= 1'b1;
        // Released data line toggles so no stale bit looks valid
        sdi <= ~sdi;
        repeat (12) @(posedge sys_clk);
    endtask : frame
endmodule : qdac_host_model
`default_nettype wire

// >>> tb/qdac_decoder_props.sv
// Checker for the decoder top; sees only its ports.
// Assumes qdac_cfg.svh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"
module qdac_decoder_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic [`QDAC_CODE_W-1:0] channel_a_output,
    input wire logic [`QDAC_CODE_W-1:0] channel_b_output,
    input wire logic [`QDAC_CODE_W-1:0] channel_c_output,
    input wire logic [`QDAC_CODE_W-1:0] channel_d_output,
    input wire logic [2*`QDAC_CH_N-1:0] channel_pd_mode,
    input wire logic input_buffers_on,
    input wire logic update_pulse
);
    wire logic [47:0] outs = {channel_a_output, channel_b_output,
        channel_c_output, channel_d_output};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_reset_state: assert property (
        $rose(rst_n) |-> channel_pd_mode == 8'hFF && outs == 48'h0 && !input_buffers_on)
        else $error("state after reset wrong");
    a_pulse_width: assert property (
        update_pulse |=> !update_pulse) else $error("update pulse too long");
    a_pulse_follows: assert property (
        $changed(outs) |-> update_pulse) else $error("no update pulse after load");
    a_pulse_cause: assert property (
        update_pulse |-> !input_buffers_on) else $error("update before frame end");
    a_out_quiet: assert property (
        input_buffers_on |-> $stable(outs) && $stable(channel_pd_mode))
        else $error("outputs moved mid frame");
    a_buf_wake: assert property (
        $fell(cs_n) |-> ##[1:5] input_buffers_on) else $error("buffers not woken");
    a_buf_rise_cause: assert property (
        $rose(input_buffers_on) |-> !cs_n && !$past(cs_n))
        else $error("buffers on without select");
    a_buf_off_hold: assert property (
        !input_buffers_on && cs_n |=> !input_buffers_on)
        else $error("buffers woke without select fall");
    cover property ($rose(update_pulse));
    cover property ($fell(input_buffers_on));
    cover property ($changed(channel_pd_mode));
endmodule : qdac_decoder_props
bind qdac_decoder qdac_decoder_props qdac_decoder_props_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
    .channel_c_output(channel_c_output), .channel_d_output(channel_d_output),
    .channel_pd_mode(channel_pd_mode), .input_buffers_on(input_buffers_on),
    .update_pulse(update_pulse));
`default_nettype wire

// >>> tb/tb_qdac_decoder.sv
// Self-checking bench for the quad DAC command decoder.
// Assumes the host model drives the link; expectations kept here.
`timescale 1ns/1ps
`default_nettype none
module tb_qdac_decoder;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    wire cs_n, sclk, sdi;
    logic [11:0] out_a, out_b, out_c, out_d;
    logic [7:0] pd;
    logic buf_on, upd;
    logic [11:0] e_out [4];
    logic [7:0] e_pd;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int upd_seen = 0;
    always #5 sys_clk = ~sys_clk;
    // Count update markers so each frame can be held to its expected count
    always @(posedge sys_clk) begin
        if (upd === 1'b1) upd_seen <= upd_seen + 1;
    end
    qdac_host_model qdac_host_model_inst (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi));
    qdac_decoder qdac_decoder_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .channel_a_output(out_a), .channel_b_output(out_b),
        .channel_c_output(out_c), .channel_d_output(out_d), .channel_pd_mode(pd),
        .input_buffers_on(buf_on), .update_pulse(upd));
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic run(input logic [15:0] w, input int n, input int extra);
        int upd_base;
        logic upd_exp;
        upd_base = upd_seen;
        // Only complete frames of commands that load an output register mark an update
        upd_exp = (n == 16) && (w[15:14] == 2'h0 || w[15:14] == 2'h2
            || w[15:12] == 4'hC || w[15:12] == 4'hE);
        qdac_host_model_inst.frame(w, n, extra);
        chk(12'(upd_seen - upd_base), {11'h000, upd_exp});
        chk(out_a, e_out[0]);
        chk(out_b, e_out[1]);
        chk(out_c, e_out[2]);
        chk(out_d, e_out[3]);
        chk({4'h0, pd}, {4'h0, e_pd});
        if (n == 16) chk({11'h000, buf_on}, 12'h000);
        $display("Test of word %h done", w);
    endtask : run
    // Hang guard, roughly three times the expected run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        e_pd = 8'hFF;
        e_out = '{4{12'h000}};
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({4'h0, pd}, 12'h0FF);
        chk(out_a | out_b | out_c | out_d, 12'h000);
        for (int ch = 0; ch < 4; ch++) begin
            e_out[ch] = 12'hA00 + 12'(ch);
            run({4'(ch), e_out[ch]}, 16, 0);
        end
        for (int ch = 0; ch < 4; ch++) run({4'(ch + 4), 12'h5A0 + 12'(ch)}, 16, 0);
        for (int ch = 0; ch < 4; ch++) begin
            e_out[ch] = 12'h5A0 + 12'(ch);
            run({4'(ch + 8), 12'hFFF}, 16, 0);
        end
        e_out = '{4{12'hFFF}};
        run(16'hCFFF, 16, 0);
        run(16'hD800, 16, 0);
        e_out = '{4{12'h800}};
        run(16'hE000, 16, 0);
        run(16'h0123, 12, 0);
        e_out[3] = 12'h001;
        run(16'h3001, 16, 8);
        for (int ch = 0; ch < 4; ch++) begin
            e_pd[2*ch +: 2] = 2'(ch);
            run({12'hF00, 2'(ch), 2'(ch)}, 16, 0);
        end
        e_pd = 8'h55;
        run(16'hF01D, 16, 0);
        e_pd = 8'h00;
        run(16'hF010, 16, 0);
        print_verdict();
    end
endmodule : tb_qdac_decoder
`default_nettype wire
